// ==== verif/crcg_top_bench.sv ====
// Self-checking testbench for the CRC generator.
`timescale 1ns/1ps

module crcg_top_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic idle_mode = 1'b0;
  logic irq;
  logic last_err;
  logic [31:0] rd;
  int bad_count = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  crcg_top i_crcg_top (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .irq(irq));

  // ------------------------------------------------------------
  // Bus tasks and reference
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // The wait ends when pready reads one; only the watchdog bounds it.
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_irq

  // Bit-serial checksum worked out from the shifter equations, one data bit per step.
  function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] p, input int pl,
    input logic [31:0] d, input int dw, input logic lsb, input logic md);
    logic b;
    logic fb;
    logic [31:0] m;
    m = 32'((64'h1 << (pl + 1)) - 64'h1);
    for (int i = 0; i <= dw; i++)
    begin
      b = lsb ? d[i] : d[dw - i];
      fb = c[pl];
      c = md ? (((c << 1) | 32'(b)) ^ (fb ? p : 32'h0)) & m : ((c << 1) ^ ((fb ^ b) ? p : 32'h0)) & m;
    end
    return c;
  endfunction : crc_ref

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  // The whole sequence needs well under a thousand cycles; ten thousand means a hang.
  initial
  begin
    #100000;
    bad_count++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    logic [31:0] p;
    logic [31:0] exp;
    logic [31:0] ctl;
    logic [31:0] w0;
    logic dir;
    logic md;
    logic sel;
    int pl;
    int dw;
    int n;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rdchk(crcg_pkg::OFS_CTRL_LOW, 32'h0000_0040);
    rdchk(crcg_pkg::OFS_POLY_HIGH, 32'h0000_0000);
    wr(crcg_pkg::OFS_POLY_LOW, 32'hFFFF_FFFF);
    rdchk(crcg_pkg::OFS_POLY_LOW, 32'h0000_FFFE);
    wr(crcg_pkg::OFS_POLY_HIGH, 32'hFFFF_FFFF);
    rdchk(crcg_pkg::OFS_POLY_HIGH, 32'h0000_FFFF);
    wr(crcg_pkg::OFS_CTRL_HIGH, 32'hFFFF_FFFF);
    rdchk(crcg_pkg::OFS_CTRL_HIGH, 32'h0000_1F1F);
    wr(crcg_pkg::OFS_CTRL_LOW, 32'h0000_0004);
    rdchk(crcg_pkg::OFS_CTRL_LOW, 32'h0000_0044);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk({31'h0, last_err}, 32'h1);
    rdchk(crcg_pkg::OFS_IRQ_CLEAR, 32'h0000_0000);
    // Long polynomial limits the FIFO to eight words; one more overflows.
    wr(crcg_pkg::OFS_IRQ_ENABLE, 32'h0000_0003);
    wr(crcg_pkg::OFS_CTRL_HIGH, 32'h0000_0707);
    wr(crcg_pkg::OFS_CTRL_LOW, 32'h0000_8000);
    repeat (8) wr(crcg_pkg::OFS_DATA, 32'h0000_0055);
    rdchk(crcg_pkg::OFS_CTRL_LOW, 32'h0000_8880);
    chk({31'h0, irq}, 32'h0);
    wr(crcg_pkg::OFS_DATA, 32'h0000_0055);
    rdchk(crcg_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    chk({31'h0, irq}, 32'h1);
    wr(crcg_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
    rdchk(crcg_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0);
    wr(crcg_pkg::OFS_IRQ_CLEAR, 32'h0000_0002);
    wr(crcg_pkg::OFS_IRQ_ENABLE, 32'h0000_0003);
    rdchk(crcg_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    // Disabling flushes; a short polynomial then allows sixteen words.
    wr(crcg_pkg::OFS_CTRL_LOW, 32'h0000_0000);
    wr(crcg_pkg::OFS_CTRL_HIGH, 32'h0000_0703);
    wr(crcg_pkg::OFS_CTRL_LOW, 32'h0000_8000);
    rdchk(crcg_pkg::OFS_CTRL_LOW, 32'h0000_8040);
    repeat (16) wr(crcg_pkg::OFS_DATA, 32'h0000_00AA);
    rdchk(crcg_pkg::OFS_CTRL_LOW, 32'h0000_9080);
    wr(crcg_pkg::OFS_CTRL_LOW, 32'h0000_0000);
    // Idle without the stop bit must not hold the shifter back.
    idle_mode <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      dir = k[0];
      md = k[1];
      sel = k[0] ^ k[1];
      pl = k[1] ? 31 : 15;
      dw = k[0] ? 11 : 7;
      p = k[1] ? 32'h04C1_1DB7 : 32'h0000_8005;
      w0 = k[0] ? 32'h0000_0A5C : 32'h0000_00C3;
      ctl = 32'h8000 | (32'(sel) << 5) | (32'(dir) << 3) | (32'(md) << 2);
      wr(crcg_pkg::OFS_CTRL_LOW, ctl);
      wr(crcg_pkg::OFS_CTRL_HIGH, {19'h0, 5'(dw), 3'h0, 5'(pl)});
      wr(crcg_pkg::OFS_POLY_LOW, {16'h0, p[15:0]});
      wr(crcg_pkg::OFS_POLY_HIGH, {16'h0, p[31:16]});
      wr(crcg_pkg::OFS_RESULT, 32'hFFFF_FFFF);
      exp = crc_ref(32'hFFFF_FFFF, {p[31:1], 1'b1}, pl, w0, dw, dir, md);
      exp = crc_ref(exp, {p[31:1], 1'b1}, pl, 32'h0000_003E, dw, dir, md);
      wr(crcg_pkg::OFS_DATA, w0);
      wr(crcg_pkg::OFS_DATA, 32'h0000_003E);
      wr(crcg_pkg::OFS_CTRL_LOW, ctl | 32'h10);
      wait_irq();
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, crcg_pkg::OFS_CTRL_LOW, 32'h0000_0000);
      chk({31'h0, rd[4]}, {31'h0, sel});
      n = 0;
      while (rd[4] !== 1'b0 && n < 50)
      begin
        apb(1'b0, crcg_pkg::OFS_CTRL_LOW, 32'h0000_0000);
        n++;
      end
      chk({31'h0, rd[4]}, 32'h0);
      rdchk(crcg_pkg::OFS_RESULT, exp);
      rdchk(crcg_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
      wr(crcg_pkg::OFS_IRQ_CLEAR, 32'h0000_0001);
      rdchk(crcg_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0);
    end
    // With the stop bit set, idle freezes the shifter until idle ends.
    wr(crcg_pkg::OFS_CTRL_LOW, 32'h0000_A000);
    wr(crcg_pkg::OFS_DATA, 32'h0000_005A);
    wr(crcg_pkg::OFS_CTRL_LOW, 32'h0000_A010);
    repeat (40) @(posedge clk);
    rdchk(crcg_pkg::OFS_CTRL_LOW, 32'h0000_A110);
    chk({31'h0, irq}, 32'h0);
    // Clearing the start bit turns the shifter off, so the word stays queued after idle ends.
    wr(crcg_pkg::OFS_CTRL_LOW, 32'h0000_A000);
    idle_mode <= 1'b0;
    repeat (40) @(posedge clk);
    rdchk(crcg_pkg::OFS_CTRL_LOW, 32'h0000_A100);
    wr(crcg_pkg::OFS_CTRL_LOW, 32'h0000_A010);
    wait_irq();
    chk({31'h0, irq}, 32'h1);
    rdchk(crcg_pkg::OFS_CTRL_LOW, 32'h0000_A040);
    report_and_stop();
  end
endmodule : crcg_top_bench

// ==== verif/crcg_top_monitor.sv ====
// Checker with register bus and interrupt assertions for the CRC generator.
`timescale 1ns/1ps

module crcg_top_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic idle_mode,
  input wire logic irq
);
  // ------------------------------------------------------------
  // Access phase sequences
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  logic bad_addr;
  assign bad_addr = (paddr > crcg_pkg::OFS_IRQ_ENABLE) || (paddr[1:0] != 2'h0);

  sequence s_rd(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence

  sequence s_wr(logic [7:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_ready_always: assert property (psel |-> pready)
    else $error("pready low during a transfer");
  a_err_unmapped: assert property (psel && penable |-> pslverr == bad_addr)
    else $error("pslverr does not match the address map");
  a_poly_bit0: assert property (s_rd(crcg_pkg::OFS_POLY_LOW) |-> prdata[0] == 1'b0)
    else $error("polynomial bit 0 read as one");
  a_count_limit: assert property (s_rd(crcg_pkg::OFS_CTRL_LOW) |-> prdata[12:8] <= 5'h10)
    else $error("word count above sixteen");
  a_empty_flag: assert property (s_rd(crcg_pkg::OFS_CTRL_LOW) |-> prdata[6] == (prdata[12:8] == 5'h00))
    else $error("empty flag disagrees with word count");
  a_flags_apart: assert property (s_rd(crcg_pkg::OFS_CTRL_LOW) |-> !(prdata[7] && prdata[6]))
    else $error("full and empty both set");
  a_width_fields: assert property (s_rd(crcg_pkg::OFS_CTRL_HIGH) |-> prdata[15:13] == 3'h0 && prdata[7:5] == 3'h0)
    else $error("unused control high bits read as one");
  a_clear_reads0: assert property (s_rd(crcg_pkg::OFS_IRQ_CLEAR) |-> prdata == 32'h0000_0000)
    else $error("clear register read not zero");
  a_irq_masked: assert property (s_wr(crcg_pkg::OFS_IRQ_ENABLE) && pwdata[1:0] == 2'h0 |-> ##2 !irq)
    else $error("interrupt stays high with all sources masked");
endmodule : crcg_top_monitor

bind crcg_top crcg_top_monitor i_crcg_top_monitor (.clk(clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode), .irq(irq));

// ==== verilog/crcg_pkg.sv ====
// Package with the register map, field layout and types of the CRC generator.
package crcg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_LOW = 8'h00;
  localparam logic [7:0] OFS_CTRL_HIGH = 8'h04;
  localparam logic [7:0] OFS_POLY_LOW = 8'h08;
  localparam logic [7:0] OFS_POLY_HIGH = 8'h0C;
  localparam logic [7:0] OFS_DATA = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int LSB_WORD_COUNT = 8;
  localparam int BIT_FULL = 7;
  localparam int BIT_EMPTY = 6;
  localparam int BIT_IRQ_SELECT = 5;
  localparam int BIT_START = 4;
  localparam int BIT_DIRECTION = 3;
  localparam int BIT_CALC_MODE = 2;
  localparam int LSB_DATA_WIDTH = 8;
  localparam int LSB_POLY_LENGTH = 0;
  localparam int BIT_IRQ_CRC = 0;
  localparam int BIT_IRQ_OVERFLOW = 1;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_POLY_LOW = 16'h0000;
  localparam logic [15:0] RST_POLY_HIGH = 16'h0000;
  localparam logic [31:0] RST_RESULT = 32'h0000_0000;
  localparam logic [4:0] DEPTH_LONG_POLY = 5'h08;
  localparam logic [4:0] DEPTH_SHORT_POLY = 5'h10;
  localparam logic [4:0] PLEN_LONG_MIN = 5'h07;
  localparam int IRQ_BITS = 2;

  typedef struct packed {
    logic module_enable;
    logic idle_stop;
    logic irq_select;
    logic shift_start;
    logic shift_direction;
    logic calc_mode;
    logic [4:0] data_width_m1;
    logic [4:0] poly_length_m1;
  } crcg_ctrl_s;

  localparam crcg_ctrl_s RST_CTRL = '0;

  typedef enum logic {
    CRCG_IDLE,
    CRCG_SHIFT
  } crcg_state_e;

endpackage : crcg_pkg

// ==== verilog/crcg_top.sv ====
// Programmable CRC generator with data FIFO and APB register slave.
// Function
// - Polynomial of any degree up to 32, chosen by per-term enable bits.
// - Data word width and polynomial length are independent settings.
// - Block runs only while the module enable bit 15 is one.
// - Idle-stop bit 13 suspends activity while the processor idles.
// - Read-only five-bit FIFO word count; limit 8 or 16 by poly length.
// - FIFO full flag bit 7 and empty flag bit 6; empty reads one after reset.
// - With interrupt select set, interrupt when the FIFO becomes empty.
// - With interrupt select clear, interrupt when shifting has finished.
// - Start bit 4 runs the shifter while one and stops it while zero.
// - Hardware clears the start bit once shifting has finished.
// - Direction bit 3 one shifts LSB first, zero shifts MSB first.
// - Calculation-mode bit 2 picks alternate or legacy calculation; resets zero.
// - Data width field holds width minus one; n processes n+1 bits.
// - Polynomial length field holds length minus one; n means degree n+1.
// - Low polynomial register holds terms 15..1; bit 0 reads zero.
// - High polynomial register holds terms 31..16, read and write.
`timescale 1ns/1ps

module crcg_top #(
  parameter int FIFO_DEPTH = 16,
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_mode,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  crcg_pkg::crcg_ctrl_s ctrl_q;
  logic [15:1] poly_low_q;
  logic [15:0] poly_high_q;
  logic [31:0] crc_q;
  logic [31:0] prdata_q;
  logic [DATA_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [$clog2(FIFO_DEPTH)-1:0] wr_ptr_q;
  logic [$clog2(FIFO_DEPTH)-1:0] rd_ptr_q;
  logic [4:0] count_q;
  logic [4:0] depth_limit;
  logic fifo_full;
  logic fifo_empty;
  logic push;
  logic pop;
  crcg_pkg::crcg_state_e state_q;
  logic [DATA_W-1:0] word_q;
  logic [4:0] bit_idx_q;
  logic work_q;
  logic run;
  logic shift_done;
  logic empty_event;
  logic data_bit;
  logic [31:0] poly;
  logic [31:0] len_mask;
  logic [31:0] crc_d;
  logic [crcg_pkg::IRQ_BITS-1:0] irq_status_q;
  logic [crcg_pkg::IRQ_BITS-1:0] irq_enable_q;
  logic [crcg_pkg::IRQ_BITS-1:0] irq_set;
  logic [crcg_pkg::IRQ_BITS-1:0] irq_clr;
  logic access_wr;
  logic setup_rd;
  logic addr_hit;
  logic overflow;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign access_wr = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;

  always_comb
  begin
    unique case (paddr)
      crcg_pkg::OFS_CTRL_LOW, crcg_pkg::OFS_CTRL_HIGH, crcg_pkg::OFS_POLY_LOW,
      crcg_pkg::OFS_POLY_HIGH, crcg_pkg::OFS_DATA, crcg_pkg::OFS_RESULT,
      crcg_pkg::OFS_IRQ_STATUS, crcg_pkg::OFS_IRQ_CLEAR, crcg_pkg::OFS_IRQ_ENABLE: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_hit;

  // ----------------------------------------------------------------
  // Control and polynomial registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= crcg_pkg::RST_CTRL;
    end
    else if (access_wr && paddr == crcg_pkg::OFS_CTRL_LOW)
    begin
      ctrl_q.module_enable <= pwdata[crcg_pkg::BIT_ENABLE];
      ctrl_q.idle_stop <= pwdata[crcg_pkg::BIT_IDLE_STOP];
      ctrl_q.irq_select <= pwdata[crcg_pkg::BIT_IRQ_SELECT];
      // A software write of one beats a completion in the same cycle, and a zero stops the shifter.
      ctrl_q.shift_start <= pwdata[crcg_pkg::BIT_START];
      ctrl_q.shift_direction <= pwdata[crcg_pkg::BIT_DIRECTION];
      ctrl_q.calc_mode <= pwdata[crcg_pkg::BIT_CALC_MODE];
    end
    else if (access_wr && paddr == crcg_pkg::OFS_CTRL_HIGH)
    begin
      ctrl_q.data_width_m1 <= pwdata[crcg_pkg::LSB_DATA_WIDTH +: 5];
      ctrl_q.poly_length_m1 <= pwdata[crcg_pkg::LSB_POLY_LENGTH +: 5];
      if (shift_done)
      begin
        ctrl_q.shift_start <= 1'b0;
      end
    end
    else if (shift_done)
    begin
      ctrl_q.shift_start <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      poly_low_q <= crcg_pkg::RST_POLY_LOW[15:1];
      poly_high_q <= crcg_pkg::RST_POLY_HIGH;
    end
    else if (access_wr && paddr == crcg_pkg::OFS_POLY_LOW)
    begin
      poly_low_q <= pwdata[15:1];
    end
    else if (access_wr && paddr == crcg_pkg::OFS_POLY_HIGH)
    begin
      poly_high_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Data FIFO
  // ----------------------------------------------------------------
  // Longer polynomials halve the usable depth.
  assign depth_limit = (ctrl_q.poly_length_m1 >= crcg_pkg::PLEN_LONG_MIN) ?
    crcg_pkg::DEPTH_LONG_POLY : crcg_pkg::DEPTH_SHORT_POLY;
  assign fifo_full = count_q >= depth_limit;
  assign fifo_empty = count_q == 5'h00;
  assign push = access_wr && paddr == crcg_pkg::OFS_DATA && ctrl_q.module_enable && !fifo_full;
  assign overflow = access_wr && paddr == crcg_pkg::OFS_DATA && ctrl_q.module_enable && fifo_full;
  assign pop = run && state_q == crcg_pkg::CRCG_IDLE && !fifo_empty;
  assign empty_event = pop && !push && count_q == 5'h01;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      fifo_mem[wr_ptr_q] <= pwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= 5'h00;
    end
    else if (!ctrl_q.module_enable)
    begin
      // Disabling the block discards any words still queued.
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= 5'h00;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 5'h01;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------
  assign run = ctrl_q.module_enable && ctrl_q.shift_start && !(ctrl_q.idle_stop && idle_mode);
  assign shift_done = run && work_q && state_q == crcg_pkg::CRCG_IDLE && fifo_empty;

  always_comb
  begin
    if (ctrl_q.shift_direction)
    begin
      data_bit = word_q[bit_idx_q];
    end
    else
    begin
      data_bit = word_q[5'(ctrl_q.data_width_m1 - bit_idx_q)];
    end
  end

  // The x^0 term is always present, so bit 0 of the polynomial is fixed.
  assign poly = {poly_high_q, poly_low_q, 1'b1};
  assign len_mask = {32{1'b1}} >> (5'd31 - ctrl_q.poly_length_m1);

  always_comb
  begin
    logic fb;
    fb = crc_q[ctrl_q.poly_length_m1];
    if (ctrl_q.calc_mode)
    begin
      // Alternate: data enters at the bottom, as an augmented message.
      crc_d = ({crc_q[30:0], data_bit} ^ (fb ? poly : 32'h0000_0000)) & len_mask;
    end
    else
    begin
      // Legacy: data is folded into the feedback at the top.
      crc_d = ({crc_q[30:0], 1'b0} ^ ((fb ^ data_bit) ? poly : 32'h0000_0000)) & len_mask;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= crcg_pkg::CRCG_IDLE;
      word_q <= '0;
      bit_idx_q <= 5'h00;
      work_q <= 1'b0;
    end
    else if (!ctrl_q.module_enable)
    begin
      state_q <= crcg_pkg::CRCG_IDLE;
      bit_idx_q <= 5'h00;
      work_q <= 1'b0;
    end
    else if (run)
    begin
      unique case (state_q)
        crcg_pkg::CRCG_IDLE:
        begin
          if (pop)
          begin
            word_q <= fifo_mem[rd_ptr_q];
            bit_idx_q <= 5'h00;
            work_q <= 1'b1;
            state_q <= crcg_pkg::CRCG_SHIFT;
          end
          else if (shift_done)
          begin
            work_q <= 1'b0;
          end
        end
        crcg_pkg::CRCG_SHIFT:
        begin
          bit_idx_q <= bit_idx_q + 5'h01;
          if (bit_idx_q == ctrl_q.data_width_m1)
          begin
            state_q <= crcg_pkg::CRCG_IDLE;
          end
        end
      endcase
    end
  end

  // Software may write the result register to load a seed value.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      crc_q <= crcg_pkg::RST_RESULT;
    end
    else if (access_wr && paddr == crcg_pkg::OFS_RESULT)
    begin
      crc_q <= pwdata;
    end
    else if (ctrl_q.module_enable && run && state_q == crcg_pkg::CRCG_SHIFT)
    begin
      crc_q <= crc_d;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_set[crcg_pkg::BIT_IRQ_CRC] = ctrl_q.irq_select ? empty_event : shift_done;
  assign irq_set[crcg_pkg::BIT_IRQ_OVERFLOW] = overflow;
  assign irq_clr = (access_wr && paddr == crcg_pkg::OFS_IRQ_CLEAR) ?
    pwdata[crcg_pkg::IRQ_BITS-1:0] : '0;

  // A set in the same cycle as its clear is kept.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_status_q <= '0;
    end
    else
    begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_enable_q <= '0;
    end
    else if (access_wr && paddr == crcg_pkg::OFS_IRQ_ENABLE)
    begin
      irq_enable_q <= pwdata[crcg_pkg::IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |((irq_status_q & ~irq_clr | irq_set) & irq_enable_q);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (setup_rd)
    begin
      prdata_q <= 32'h0000_0000;
      unique case (paddr)
        crcg_pkg::OFS_CTRL_LOW:
        begin
          prdata_q[crcg_pkg::BIT_ENABLE] <= ctrl_q.module_enable;
          prdata_q[crcg_pkg::BIT_IDLE_STOP] <= ctrl_q.idle_stop;
          prdata_q[crcg_pkg::LSB_WORD_COUNT +: 5] <= count_q;
          prdata_q[crcg_pkg::BIT_FULL] <= fifo_full;
          prdata_q[crcg_pkg::BIT_EMPTY] <= fifo_empty;
          prdata_q[crcg_pkg::BIT_IRQ_SELECT] <= ctrl_q.irq_select;
          prdata_q[crcg_pkg::BIT_START] <= ctrl_q.shift_start;
          prdata_q[crcg_pkg::BIT_DIRECTION] <= ctrl_q.shift_direction;
          prdata_q[crcg_pkg::BIT_CALC_MODE] <= ctrl_q.calc_mode;
        end
        crcg_pkg::OFS_CTRL_HIGH:
        begin
          prdata_q[crcg_pkg::LSB_DATA_WIDTH +: 5] <= ctrl_q.data_width_m1;
          prdata_q[crcg_pkg::LSB_POLY_LENGTH +: 5] <= ctrl_q.poly_length_m1;
        end
        crcg_pkg::OFS_POLY_LOW: prdata_q[15:0] <= {poly_low_q, 1'b0};
        crcg_pkg::OFS_POLY_HIGH: prdata_q[15:0] <= poly_high_q;
        crcg_pkg::OFS_RESULT: prdata_q <= crc_q & len_mask;
        crcg_pkg::OFS_IRQ_STATUS: prdata_q[crcg_pkg::IRQ_BITS-1:0] <= irq_status_q;
        crcg_pkg::OFS_IRQ_ENABLE: prdata_q[crcg_pkg::IRQ_BITS-1:0] <= irq_enable_q;
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_q;

endmodule : crcg_top
